// ==== sync_edge_adjust.sv ====
// sync edge adjust: register file, config crossing, lookahead pipeline
`timescale 1ns/1ps
// Summary of operation
// - frame pulse lasts four pixel clocks by default
// - line pulse lasts four pixel clocks by default
// - level mode covers whole row or frame
// - line end code shifts inactive edge
// - line code eight is neutral, up adds
// - line code zero suppresses; low codes reserved
// - frame end code decoded likewise, up +24
// - start codes move active edge earlier
// - line mode bit selects level or pulse
// - frame mode bit selects level or pulse
module sync_edge_adjust (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       line_sync_pulse_select,
  input  wire logic       frame_sync_pulse_select,
  input  wire logic       pclk,
  input  wire logic       row_valid,
  input  wire logic       frame_valid,
  input  wire logic [9:0] pixel_in,
  output logic      [9:0] pixel_out,
  output logic            line_sync,
  output logic            frame_sync
);
  localparam int TW = sync_adjust_pkg::TAPS;
  localparam int LA = sync_adjust_pkg::LOOKAHEAD;
  localparam int CW = sync_adjust_pkg::CFG_W;

  // system clock reset release
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // pixel clock reset release
  logic prst_meta_r;
  logic prst_n;
  always_ff @(posedge pclk or negedge resetn) begin
    if (!resetn) begin
      prst_meta_r <= 1'b0;
      prst_n      <= 1'b0;
    end else begin
      prst_meta_r <= 1'b1;
      prst_n      <= prst_meta_r;
    end
  end

  // register file
  logic [sync_adjust_pkg::FRAME_END_W-1:0] frame_sync_end_code_r;
  logic [sync_adjust_pkg::LINE_END_W-1:0]  line_sync_end_code_r;
  logic [7:0]                              sync_start_adjust_r;

  wire hit_frame = (reg_addr == sync_adjust_pkg::FRAME_END_OFFSET);
  wire hit_line  = (reg_addr == sync_adjust_pkg::LINE_END_OFFSET);
  wire hit_start = (reg_addr == sync_adjust_pkg::START_OFFSET);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      frame_sync_end_code_r <= sync_adjust_pkg::FRAME_END_RESET;
      line_sync_end_code_r  <= sync_adjust_pkg::LINE_END_RESET;
      sync_start_adjust_r   <= sync_adjust_pkg::START_RESET;
    end else if (reg_wr) begin
      if (hit_frame) begin
        frame_sync_end_code_r <= reg_wdata[sync_adjust_pkg::FRAME_END_W-1:0];
      end
      if (hit_line) begin
        line_sync_end_code_r <= reg_wdata[sync_adjust_pkg::LINE_END_W-1:0];
      end
      if (hit_start) begin
        sync_start_adjust_r <= reg_wdata;
      end
    end
  end

  // reserved bits read as zero; unmapped addresses read zero
  wire [7:0] rdata_sel = hit_frame ? {3'h0, frame_sync_end_code_r} :
                         hit_line  ? {4'h0, line_sync_end_code_r} :
                         hit_start ? sync_start_adjust_r : 8'h00;
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_sel;
    end
  end

  // mode select pins arrive asynchronously
  logic [1:0] mode_meta_r;
  logic [1:0] mode_r;
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_meta_r <= 2'b00;
      mode_r      <= 2'b00;
    end else begin
      mode_meta_r <= {frame_sync_pulse_select, line_sync_pulse_select};
      mode_r      <= mode_meta_r;
    end
  end

  // word crossing by toggle handshake; the shadow only changes while no transfer is open
  wire [CW-1:0] cfg_live = {mode_r, frame_sync_end_code_r, line_sync_end_code_r, sync_start_adjust_r};
  logic [CW-1:0] shadow_r;
  logic          req_r;
  logic          ack_meta_r;
  logic          ack_r;
  logic          ack_pix_r;
  wire           idle = (req_r == ack_r);
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shadow_r   <= {2'b00, sync_adjust_pkg::FRAME_END_RESET, sync_adjust_pkg::LINE_END_RESET,
                     sync_adjust_pkg::START_RESET};
      req_r      <= 1'b0;
      ack_meta_r <= 1'b0;
      ack_r      <= 1'b0;
    end else begin
      ack_meta_r <= ack_pix_r;
      ack_r      <= ack_meta_r;
      if (idle && (shadow_r != cfg_live)) begin
        shadow_r <= cfg_live;
        req_r    <= ~req_r;
      end
    end
  end

  logic          req_meta_r;
  logic          req_pix_r;
  logic [CW-1:0] cfg_pix_r;
  always_ff @(posedge pclk or negedge prst_n) begin
    if (!prst_n) begin
      req_meta_r <= 1'b0;
      req_pix_r  <= 1'b0;
      ack_pix_r  <= 1'b0;
      cfg_pix_r  <= {2'b00, sync_adjust_pkg::FRAME_END_RESET, sync_adjust_pkg::LINE_END_RESET,
                     sync_adjust_pkg::START_RESET};
    end else begin
      req_meta_r <= req_r;
      req_pix_r  <= req_meta_r;
      ack_pix_r  <= req_pix_r;
      if (req_pix_r != ack_pix_r) begin
        cfg_pix_r <= shadow_r;
      end
    end
  end

  // lookahead pipeline: pixels and syncs leave LOOKAHEAD+2 clocks late, so edges can move earlier
  logic [TW-1:0]                       row_taps_r;
  logic [TW-1:0]                       frame_taps_r;
  logic [sync_adjust_pkg::PIXEL_W-1:0] pix_pipe_r [0:LA];
  always_ff @(posedge pclk or negedge prst_n) begin
    if (!prst_n) begin
      row_taps_r   <= '0;
      frame_taps_r <= '0;
    end else begin
      row_taps_r   <= {row_taps_r[TW-2:0], row_valid};
      frame_taps_r <= {frame_taps_r[TW-2:0], frame_valid};
    end
  end

  always_ff @(posedge pclk) begin
    pix_pipe_r[0] <= pixel_in;
    for (int i = 1; i <= LA; i++) begin
      pix_pipe_r[i] <= pix_pipe_r[i-1];
    end
  end

  always_ff @(posedge pclk or negedge prst_n) begin
    if (!prst_n) begin
      pixel_out <= 10'h000;
    end else begin
      // as many stages as the taps: keeps pixels aligned with the shaper's output flop
      pixel_out <= pix_pipe_r[LA];
    end
  end

  sync_shape_if #(.EW(sync_adjust_pkg::LINE_END_W))  line_if ();
  sync_shape_if #(.EW(sync_adjust_pkg::FRAME_END_W)) frame_if ();

  assign line_if.taps        = row_taps_r;
  assign line_if.start_code  = cfg_pix_r[sync_adjust_pkg::LINE_START_POS +: sync_adjust_pkg::START_W];
  assign line_if.end_code    = cfg_pix_r[8 +: sync_adjust_pkg::LINE_END_W];
  assign line_if.pulse_sel   = cfg_pix_r[17];
  assign frame_if.taps       = frame_taps_r;
  assign frame_if.start_code = cfg_pix_r[sync_adjust_pkg::FRAME_START_POS +: sync_adjust_pkg::START_W];
  assign frame_if.end_code   = cfg_pix_r[12 +: sync_adjust_pkg::FRAME_END_W];
  assign frame_if.pulse_sel  = cfg_pix_r[18];

  sync_shaper #(
    .EW      (sync_adjust_pkg::LINE_END_W),
    .MAX_ADJ (sync_adjust_pkg::LINE_MAX_ADJUST)
  ) u_line (
    .pclk   (pclk),
    .prst_n (prst_n),
    .sh     (line_if.shaper)
  );

  sync_shaper #(
    .EW      (sync_adjust_pkg::FRAME_END_W),
    .MAX_ADJ (sync_adjust_pkg::FRAME_MAX_ADJUST)
  ) u_frame (
    .pclk   (pclk),
    .prst_n (prst_n),
    .sh     (frame_if.shaper)
  );

  assign line_sync  = line_if.sync_out;
  assign frame_sync = frame_if.sync_out;
endmodule

// ==== sync_adjust_pkg.sv ====
// constants shared by the sync edge adjust block
package sync_adjust_pkg;
  localparam logic [7:0] FRAME_END_OFFSET  = 8'h50;
  localparam logic [7:0] LINE_END_OFFSET   = 8'h51;
  localparam logic [7:0] START_OFFSET      = 8'h52;
  localparam logic [4:0] FRAME_END_RESET   = 5'h08;
  localparam logic [3:0] LINE_END_RESET    = 4'h8;
  localparam logic [7:0] START_RESET       = 8'h00;
  localparam int         FRAME_END_W       = 5;
  localparam int         LINE_END_W        = 4;
  localparam int         START_W           = 4;
  localparam int         FRAME_START_POS   = 4;
  localparam int         LINE_START_POS    = 0;
  localparam int         NO_ADJUST_CODE    = 8;
  localparam int         FRAME_MAX_ADJUST  = 24;
  localparam int         LINE_MAX_ADJUST   = 8;
  localparam logic [5:0] PULSE_CYCLES      = 6'h04;
  localparam int         LOOKAHEAD         = 15;
  localparam int         TAPS              = LOOKAHEAD + 2;
  localparam int         PIXEL_W           = 10;
  localparam int         CFG_W             = 19;
endpackage

// ==== sync_shape_if.sv ====
// bundle between the top and one sync shaper
`timescale 1ns/1ps
interface sync_shape_if #(parameter int EW = 4);
  logic [sync_adjust_pkg::TAPS-1:0]    taps;
  logic [sync_adjust_pkg::START_W-1:0] start_code;
  logic [EW-1:0]                       end_code;
  logic                                pulse_sel;
  logic                                sync_out;
  modport ctl    (output taps, start_code, end_code, pulse_sel, input sync_out);
  modport shaper (input taps, start_code, end_code, pulse_sel, output sync_out);
endinterface

// ==== sync_shaper.sv ====
// one sync output shaper on the pixel clock
`timescale 1ns/1ps
module sync_shaper #(
  parameter int EW      = 4,
  parameter int MAX_ADJ = 8
) (
  input  wire logic   pclk,
  input  wire logic   prst_n,
  sync_shape_if.shaper sh
);
  localparam logic [EW-1:0] ALL_ONES = {EW{1'b1}};
  localparam logic [EW-1:0] NO_ADJ   = EW'(sync_adjust_pkg::NO_ADJUST_CODE);

  logic       active_r;
  logic       active_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       sync_r;

  // tap k holds the nominal valid level k+1 cycles ago; the output is aligned to LOOKAHEAD
  wire [4:0] early_idx  = 5'(sync_adjust_pkg::LOOKAHEAD) - 5'(sh.start_code);
  wire       early_cur  = sh.taps[early_idx];
  wire       early_prev = sh.taps[early_idx + 5'd1];
  wire       rise_early = early_cur & ~early_prev;
  wire       fall_early = ~early_cur & early_prev;
  wire       fall_ref   = ~sh.taps[sync_adjust_pkg::LOOKAHEAD] & sh.taps[sync_adjust_pkg::LOOKAHEAD+1];
  // reserved codes behave as no adjustment
  wire       suppress   = (sh.end_code == '0);
  wire [5:0] adj        = (sh.end_code == ALL_ONES) ? 6'(MAX_ADJ) :
                          (sh.end_code > NO_ADJ) ? 6'(sh.end_code - NO_ADJ) : 6'h00;
  wire [5:0] tail       = (sh.pulse_sel ? sync_adjust_pkg::PULSE_CYCLES : 6'h00) + adj;
  wire       start_evt  = sh.pulse_sel ? fall_early : rise_early;

  always_comb begin
    active_nxt = active_r;
    cnt_nxt    = cnt_r;
    if (cnt_r != 6'h00) begin
      cnt_nxt = cnt_r - 6'h01;
      if (cnt_r == 6'h01) begin
        active_nxt = 1'b0;
      end
    end
    // with no start shift a pulse begins on the end event itself, so that edge must load the tail too
    if (fall_ref & (active_r | (start_evt & sh.pulse_sel))) begin
      cnt_nxt    = tail;
      active_nxt = (tail != 6'h00);
    end
    if (start_evt) begin
      active_nxt = 1'b1;
      if (!sh.pulse_sel) begin
        cnt_nxt = 6'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge prst_n) begin
    if (!prst_n) begin
      active_r <= 1'b0;
      cnt_r    <= 6'h00;
      sync_r   <= 1'b0;
    end else begin
      active_r <= active_nxt;
      cnt_r    <= cnt_nxt;
      sync_r   <= active_nxt & ~suppress;
    end
  end

  assign sh.sync_out = sync_r;
endmodule

// ==== pixel_host.sv ====
// host model that timestamps sync edges on the pixel clock
`timescale 1ns/1ps
module pixel_host (
  input wire logic pclk,
  input wire logic line_sync,
  input wire logic frame_sync
);
  int   n = 0;
  int   ls_q[$];
  int   fs_q[$];
  logic l_r = 1'b0;
  logic f_r = 1'b0;
  // edges, not levels: a level latch could miss a narrow pulse
  always @(posedge pclk) begin
    n <= n + 1;
    l_r <= line_sync;
    f_r <= frame_sync;
    if (line_sync != l_r) ls_q.push_back(n);
    if (frame_sync != f_r) fs_q.push_back(n);
  end
endmodule

// ==== sync_edge_adjust_chk.sv ====
// assertions on the pixel side of the sync edge adjust block
`timescale 1ns/1ps
module sync_edge_adjust_chk (
  input wire logic       pclk,
  input wire logic       resetn,
  input wire logic       line_sync_pulse_select,
  input wire logic       frame_sync_pulse_select,
  input wire logic       row_valid,
  input wire logic       frame_valid,
  input wire logic [9:0] pixel_in,
  input wire logic [9:0] pixel_out,
  input wire logic       line_sync,
  input wire logic       frame_sync
);
  logic [7:0] q_r, lr_r, lf_r, ff_r;
  logic       rv_r, fv_r, lm_r, fm_r;
  // checks wait 60 pclk after reset or a mode change, past the pin synchroniser
  wire        ok = q_r > 8'h3B;
  wire        ll = ok && !line_sync_pulse_select;
  wire        lp = ok && line_sync_pulse_select;
  wire        fl = ok && !frame_sync_pulse_select;
  wire        fp = ok && frame_sync_pulse_select;
  function automatic logic [7:0] inc(input logic [7:0] x);
    return (x == 8'hFF) ? x : x + 8'h01;
  endfunction
  always_ff @(posedge pclk or negedge resetn) begin
    if (!resetn) begin
      {rv_r, fv_r, lm_r, fm_r, q_r} <= '0;
      {lr_r, lf_r, ff_r} <= '1;
    end else begin
      {rv_r, fv_r, lm_r, fm_r} <= {row_valid, frame_valid, line_sync_pulse_select, frame_sync_pulse_select};
      q_r <= ({lm_r, fm_r} != {line_sync_pulse_select, frame_sync_pulse_select}) ? 8'h00 : inc(q_r);
      lr_r <= (row_valid && !rv_r) ? 8'h01 : inc(lr_r);
      lf_r <= (!row_valid && rv_r) ? 8'h01 : inc(lf_r);
      ff_r <= (!frame_valid && fv_r) ? 8'h01 : inc(ff_r);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!resetn);
  property p_llr;
    $rose(line_sync) && ll |-> lr_r inside {[2:17]};
  endproperty
  a_llr: assert property (p_llr) else $error("line level rise off");
  property p_llf;
    $fell(line_sync) && ll |-> lf_r inside {[17:25]};
  endproperty
  a_llf: assert property (p_llf) else $error("line level fall off");
  property p_lpr;
    $rose(line_sync) && lp |-> lf_r inside {[2:17]};
  endproperty
  a_lpr: assert property (p_lpr) else $error("line pulse rise off");
  property p_lpf;
    $fell(line_sync) && lp |-> lf_r inside {[21:29]};
  endproperty
  a_lpf: assert property (p_lpf) else $error("line pulse fall off");
  property p_flf;
    $fell(frame_sync) && fl |-> ff_r inside {[17:41]};
  endproperty
  a_flf: assert property (p_flf) else $error("frame level fall off");
  property p_fpr;
    $rose(frame_sync) && fp |-> ff_r inside {[2:17]};
  endproperty
  a_fpr: assert property (p_fpr) else $error("frame pulse rise off");
  property p_fpf;
    $fell(frame_sync) && fp |-> ff_r inside {[21:45]};
  endproperty
  a_fpf: assert property (p_fpf) else $error("frame pulse fall off");
  property p_pix;
    ok |-> pixel_out == $past(pixel_in, 17);
  endproperty
  a_pix: assert property (p_pix) else $error("pixel delay off");
endmodule
bind sync_edge_adjust sync_edge_adjust_chk chk (.pclk(pclk), .resetn(resetn),
  .line_sync_pulse_select(line_sync_pulse_select), .frame_sync_pulse_select(frame_sync_pulse_select),
  .row_valid(row_valid), .frame_valid(frame_valid), .pixel_in(pixel_in), .pixel_out(pixel_out),
  .line_sync(line_sync), .frame_sync(frame_sync));

// ==== sync_edge_adjust_bench.sv ====
// self-checking bench for the sync edge adjust block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module sync_edge_adjust_bench;
  logic       clock = 1'b0, pclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, row_valid = 1'b0, frame_valid = 1'b0;
  logic       line_sync_pulse_select = 1'b0, frame_sync_pulse_select = 1'b0, line_sync, frame_sync;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [9:0] pixel_in = 10'h000, pixel_out;
  int         n_fail = 0, compares = 0, lc, fc, st, k1, k2;
  int         m[3] = '{8, 8, 0};
  int         mk[3] = '{'h1F, 'h0F, 'hFF};
  int         lt[4] = '{8, 0, 15, 14};
  int         ft[4] = '{8, 0, 31, 30};
  int         stt[4] = '{0, 0, 'hFF, 'h5A};
  initial forever #5 clock = ~clock;
  initial begin
    #7;
    forever #24 pclk = ~pclk;
  end
  always @(posedge pclk) pixel_in <= 10'($urandom);
  sync_edge_adjust dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_sync_pulse_select(line_sync_pulse_select),
    .frame_sync_pulse_select(frame_sync_pulse_select), .pclk(pclk), .row_valid(row_valid),
    .frame_valid(frame_valid), .pixel_in(pixel_in), .pixel_out(pixel_out), .line_sync(line_sync),
    .frame_sync(frame_sync));
  pixel_host host (.pclk(pclk), .line_sync(line_sync), .frame_sync(frame_sync));
  // pixel model: each pixel leaves as many clocks late as the syncs, seen one edge after its launch
  int pq[$];
  always @(posedge pclk) begin
    pq.push_back(pixel_in);
    if (pq.size() > 18) void'(pq.pop_front());
    if (pq.size() == 18 && host.n > 30) `CHK(pixel_out, 10'(pq[0]))
  end
  task automatic wr(int a, int d);
    @(posedge clock);
    reg_addr <= 8'(a);
    reg_wdata <= 8'(d);
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    m[a - 'h50] = d & mk[a - 'h50];
  endtask
  task automatic rd(int a, int e);
    @(posedge clock);
    reg_addr <= 8'(a);
    repeat (2) @(posedge clock);
    `CHK(reg_rdata, 8'(e))
  endtask
  // q holds rise then fall stamps; k1/k2 are the stamps of the row start and end drives
  task automatic sync_chk(int c, int s, bit p, int top, int mx, int k1, int k2, int q[$]);
    `CHK(q.size(), (c == 0) ? 0 : 2)
    if (c != 0 && q.size() == 2) begin
      `CHK(q[0], (p ? k2 : k1) + 18 - s)
      `CHK(q[1], k2 + (p ? 22 : 18) + ((c == top) ? mx : (c > 8) ? c - 8 : 0))
    end
  endtask
  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    test_done;
  end
  initial begin
    void'($urandom(65218));
    repeat (3) @(posedge pclk);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 12; i++) begin
      // first pass reads reset values; 0x53 is unmapped and reads zero
      for (int a = 'h50; a < 'h54; a++) rd(a, (a < 'h53) ? m[a - 'h50] : 0);
      lc = (i < 4) ? lt[i] : 8 + $urandom % 8;
      fc = (i < 4) ? ft[i] : 8 + $urandom % 24;
      st = (i < 4) ? stt[i] : $urandom % 256;
      wr('h50, fc | 'hE0);
      wr('h51, lc | 'hF0);
      wr('h52, st);
      for (int a = 'h50; a < 'h53; a++) rd(a, m[a - 'h50]);
      line_sync_pulse_select <= !i[0];
      frame_sync_pulse_select <= !i[1];
      repeat (64) @(posedge pclk);
      host.ls_q.delete();
      host.fs_q.delete();
      frame_valid <= 1'b1;
      row_valid <= 1'b1;
      k1 = host.n;
      repeat (40) @(posedge pclk);
      frame_valid <= 1'b0;
      row_valid <= 1'b0;
      k2 = host.n;
      repeat (80) @(posedge pclk);
      sync_chk(lc, st % 16, !i[0], 15, 8, k1, k2, host.ls_q);
      sync_chk(fc, st / 16, !i[1], 31, 24, k1, k2, host.fs_q);
    end
    test_done;
  end
endmodule
